// file: rtl/host_port_dev.sv
// Device host port with width strap, half pairing and FIFO
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wptr_ff;
  logic [PW-1:0] rptr_ff;
  logic [PW:0] count_ff;
  logic push;
  logic pop;
  assign o_in_ready = (count_ff != (PW+1)'(DEPTH));
  assign o_out_valid = (count_ff != '0);
  assign o_out_data = mem_ff[rptr_ff];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem_ff[wptr_ff] <= i_in_data;
    end
  end
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_ff <= (wptr_ff == PW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
      end
      if (pop)
      begin
        rptr_ff <= (rptr_ff == PW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
      end
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // sync_fifo

module host_port_dev (
  input wire logic i_mclk,
  input wire logic i_nrst,
  hbus_if.dev bus,
  input wire logic i_width_strap,
  output logic o_wr_valid,
  output logic [hbus_pkg::DW_ADDR_W-1:0] o_wr_addr,
  output logic [hbus_pkg::DATA_W-1:0] o_wr_data,
  input wire logic i_wr_ready,
  output logic o_rd_req,
  output logic [hbus_pkg::DW_ADDR_W-1:0] o_rd_addr,
  input wire logic [hbus_pkg::DATA_W-1:0] i_rd_data,
  output logic o_is_32bit
);
  import hbus_pkg::*;

  logic strap1_ff;
  logic strap2_ff;
  logic strap3_ff;
  logic width32_ff;
  logic [31:0] order_ff;
  logic wpend_ff;
  logic whalf_ff;
  logic [15:0] wbuf_ff;
  logic rpend_ff;
  logic [31:0] rlatch_ff;
  logic rstage_ff;
  logic rstage_half_ff;
  logic rstage_fetch_ff;
  logic [7:0] rstage_addr_ff;
  logic [31:0] rdata_ff;
  logic oe_lo_ff;
  logic oe_hi_ff;
  logic rvalid_ff;
  logic ready_ff;
  logic is16;
  logic half;
  logic [7:0] byte_addr;
  logic commit;
  logic [31:0] commit_data;
  logic fifo_push;
  logic fifo_in_ready;
  logic [31:0] fetched;

  // Internal half: 0 = bytes 1:0, 1 = bytes 3:2
  function automatic logic map_half(input logic a1, input logic [31:0] ctl);
    map_half = a1 ^ (ctl == ORDER_SWAP);
  endfunction

  function automatic logic [31:0] place(input logic h, input logic [15:0] d,
                                        input logic [15:0] other);
    place = h ? {d, other} : {other, d};
  endfunction

  assign is16 = ~width32_ff;
  assign byte_addr = {bus.addr[7:2], 2'b00};
  assign half = is16 & map_half(bus.addr[1], order_ff);

  // Strap sync: accept only when stages two and three agree
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      strap1_ff <= 1'b0;
      strap2_ff <= 1'b0;
      strap3_ff <= 1'b0;
      width32_ff <= 1'b0;
    end
    else
    begin
      strap1_ff <= i_width_strap;
      strap2_ff <= strap1_ff;
      strap3_ff <= strap2_ff;
      if (strap2_ff == strap3_ff)
      begin
        width32_ff <= strap3_ff;
      end
    end
  end
  assign o_is_32bit = width32_ff;

  // Write pairing
  always_comb
  begin
    commit = 1'b0;
    commit_data = bus.wdata;
    if (bus.wr)
    begin
      if (!is16)
      begin
        commit = 1'b1;
      end
      else if (wpend_ff && (half != whalf_ff))
      begin
        commit = 1'b1;
        commit_data = place(half, bus.wdata[15:0], wbuf_ff);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wpend_ff <= 1'b0;
      whalf_ff <= 1'b0;
      wbuf_ff <= 16'h0000;
    end
    else if (bus.wr && is16)
    begin
      if (!wpend_ff)
      begin
        wpend_ff <= 1'b1;
        whalf_ff <= half;
        wbuf_ff <= bus.wdata[15:0];
      end
      else if (half != whalf_ff)
      begin
        wpend_ff <= 1'b0;
      end
      // Same half again: dropped, first half stays pending
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      order_ff <= ORDER_RST;
    end
    else if (commit && byte_addr == ORDER_OFF)
    begin
      order_ff <= commit_data;
    end
  end

  // Dwords to the data side; registers are kept local
  assign fifo_push = commit && byte_addr != ORDER_OFF && byte_addr != CFG_OFF;

  sync_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_in_valid(fifo_push),
    .i_in_data({bus.addr[7:2], commit_data}),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(o_wr_valid),
    .o_out_data({o_wr_addr, o_wr_data}),
    .i_out_ready(i_wr_ready)
  );

  // Ready drops the cycle after a push so the host cannot overrun
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ready_ff <= 1'b0;
    end
    else
    begin
      ready_ff <= fifo_in_ready & ~fifo_push;
    end
  end

  // Read stage one: decide fetch and half
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rpend_ff <= 1'b0;
      rstage_ff <= 1'b0;
      rstage_half_ff <= 1'b0;
      rstage_fetch_ff <= 1'b0;
      rstage_addr_ff <= 8'h00;
      o_rd_req <= 1'b0;
      o_rd_addr <= '0;
    end
    else
    begin
      rstage_ff <= bus.rd;
      o_rd_req <= 1'b0;
      if (bus.rd)
      begin
        rstage_half_ff <= half;
        rstage_addr_ff <= byte_addr;
        rstage_fetch_ff <= ~is16 | ~rpend_ff;
        if (!is16 || !rpend_ff)
        begin
          o_rd_req <= byte_addr != ORDER_OFF && byte_addr != CFG_OFF;
          o_rd_addr <= bus.addr[7:2];
        end
        if (is16 && !rpend_ff)
        begin
          rpend_ff <= 1'b1;
        end
        else
        begin
          // Second half or same-half repeat both restart pairing
          rpend_ff <= 1'b0;
        end
      end
    end
  end

  always_comb
  begin
    if (rstage_addr_ff == CFG_OFF)
    begin
      fetched = 32'h00000000;
      fetched[CFG_WIDTH_BIT] = width32_ff;
    end
    else if (rstage_addr_ff == ORDER_OFF)
    begin
      fetched = order_ff;
    end
    else
    begin
      fetched = i_rd_data;
    end
  end

  // Read stage two: drive the lanes
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rlatch_ff <= 32'h00000000;
      rdata_ff <= 32'h00000000;
      oe_lo_ff <= 1'b0;
      oe_hi_ff <= 1'b0;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= rstage_ff;
      oe_lo_ff <= rstage_ff;
      oe_hi_ff <= rstage_ff & width32_ff;
      if (rstage_ff)
      begin
        if (rstage_fetch_ff)
        begin
          rlatch_ff <= fetched;
        end
        if (width32_ff)
        begin
          rdata_ff <= fetched;
        end
        else if (rstage_fetch_ff)
        begin
          rdata_ff <= {16'h0000, rstage_half_ff ? fetched[31:16]
                                                : fetched[15:0]};
        end
        else
        begin
          rdata_ff <= {16'h0000, rstage_half_ff ? rlatch_ff[31:16]
                                                : rlatch_ff[15:0]};
        end
      end
    end
  end

  assign bus.rdata = rdata_ff;
  assign bus.oe_lo = oe_lo_ff;
  assign bus.oe_hi = oe_hi_ff;
  assign bus.rvalid = rvalid_ff;
  assign bus.ready = ready_ff;
endmodule // host_port_dev

// file: pkg/hbus_pkg.sv
// Shared constants and types for the host port and its controller
package hbus_pkg;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int ADDR_HI = 7;
  localparam int DW_ADDR_W = 6;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = DW_ADDR_W + DATA_W;
  // Device-side register byte addresses
  localparam logic [7:0] CFG_OFF = 8'h74;
  localparam logic [7:0] ORDER_OFF = 8'h98;
  localparam int CFG_WIDTH_BIT = 2;
  localparam logic [31:0] ORDER_RST = 32'h00000000;
  localparam logic [31:0] ORDER_SWAP = 32'hFFFFFFFF;
  // Controller registers on AHB-Lite
  localparam logic [7:0] H_CTRL_OFF = 8'h00;
  localparam logic [7:0] H_ADDR_OFF = 8'h04;
  localparam logic [7:0] H_WDATA_OFF = 8'h08;
  localparam logic [7:0] H_RDATA_OFF = 8'h0C;
  localparam logic [7:0] H_STAT_OFF = 8'h10;
  localparam int CTRL_GO_WR_BIT = 0;
  localparam int CTRL_GO_RD_BIT = 1;
  localparam int CTRL_MODE16_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  typedef enum logic [2:0] {
    H_IDLE,
    H_WAIT_RDY,
    H_ISSUE,
    H_WAIT_RD,
    H_NEXT
  } host_state_type;
endpackage

// file: pkg/hbus_if.sv
// Parallel host bus between controller and device port
`timescale 1ns/1ps
interface hbus_if;
  logic [7:1] addr;
  logic wr;
  logic rd;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic oe_lo;
  logic oe_hi;
  logic rvalid;
  logic ready;
  wire [31:0] dq;
  // Pull-downs hold undriven upper lanes low
  assign dq[15:0] = oe_lo ? rdata[15:0] : (wr ? wdata[15:0] : 16'h0000);
  assign dq[31:16] = oe_hi ? rdata[31:16] :
    (wr ? wdata[31:16] : 16'h0000);
  modport dev (
    input addr, wr, rd, wdata,
    output rdata, oe_lo, oe_hi, rvalid, ready
  );
  modport host (
    output addr, wr, rd, wdata,
    input dq, rvalid, ready
  );
endinterface

// file: rtl/host_ctrl.sv
// Host-side controller: AHB-Lite registers driving the parallel bus
`timescale 1ns/1ps
module host_ctrl (
  input wire logic i_mclk,
  input wire logic i_nrst,
  hbus_if.host bus,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp
);
  import hbus_pkg::*;

  host_state_type state_ff;
  logic [7:0] dphase_addr_ff;
  logic dphase_wr_ff;
  logic [7:0] tgt_addr_ff;
  logic [31:0] wdata_ff;
  logic [31:0] rdata_ff;
  logic mode16_ff;
  logic is_read_ff;
  logic done_ff;
  logic half_ff;
  logic [7:1] addr_ff;
  logic wr_ff;
  logic rd_ff;
  logic [31:0] out_ff;
  logic aphase;
  logic reg_wr;
  logic go;
  logic finish;

  assign aphase = i_hsel & i_htrans[1] & i_hready;
  assign reg_wr = dphase_wr_ff;
  assign go = reg_wr && dphase_addr_ff == H_CTRL_OFF && state_ff == H_IDLE &&
    (i_hwdata[CTRL_GO_WR_BIT] | i_hwdata[CTRL_GO_RD_BIT]);
  assign finish = state_ff == H_NEXT && (!mode16_ff || half_ff);

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      dphase_wr_ff <= 1'b0;
      dphase_addr_ff <= 8'h00;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
    else
    begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      dphase_wr_ff <= aphase & i_hwrite;
      if (aphase)
      begin
        dphase_addr_ff <= i_haddr[7:0];
        case (i_haddr[7:0])
          H_CTRL_OFF: o_hrdata <= {29'h0, mode16_ff, 2'b00};
          H_ADDR_OFF: o_hrdata <= {24'h0, tgt_addr_ff};
          H_WDATA_OFF: o_hrdata <= wdata_ff;
          H_RDATA_OFF: o_hrdata <= rdata_ff;
          H_STAT_OFF: o_hrdata <= {30'h0, done_ff, state_ff != H_IDLE};
          default: o_hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tgt_addr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      mode16_ff <= 1'b0;
      is_read_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      if (reg_wr && state_ff == H_IDLE)
      begin
        case (dphase_addr_ff)
          H_ADDR_OFF: tgt_addr_ff <= i_hwdata[7:0];
          H_WDATA_OFF: wdata_ff <= i_hwdata;
          H_CTRL_OFF:
          begin
            mode16_ff <= i_hwdata[CTRL_MODE16_BIT];
            is_read_ff <= i_hwdata[CTRL_GO_RD_BIT];
          end
          default: ;
        endcase
      end
      // Completion wins over a clear in the same cycle
      if (finish)
      begin
        done_ff <= 1'b1;
      end
      else if (reg_wr && dphase_addr_ff == H_STAT_OFF &&
               i_hwdata[STAT_DONE_BIT])
      begin
        done_ff <= 1'b0;
      end
    end
  end

  // Halves go low first, A1 toggled, upper address held
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_ff <= H_IDLE;
      half_ff <= 1'b0;
      addr_ff <= 7'h00;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      out_ff <= 32'h00000000;
      rdata_ff <= 32'h00000000;
    end
    else
    begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      case (state_ff)
        H_IDLE:
        begin
          half_ff <= 1'b0;
          if (go)
          begin
            state_ff <= H_WAIT_RDY;
          end
        end
        H_WAIT_RDY:
        begin
          if (bus.ready || is_read_ff)
          begin
            // Single transfers keep the target's A1 so a lone half can go
            addr_ff <= {tgt_addr_ff[7:2],
                        mode16_ff ? half_ff : tgt_addr_ff[1]};
            out_ff <= !mode16_ff ? wdata_ff :
              {16'h0000, half_ff ? wdata_ff[31:16] : wdata_ff[15:0]};
            wr_ff <= ~is_read_ff;
            rd_ff <= is_read_ff;
            state_ff <= H_ISSUE;
          end
        end
        H_ISSUE:
        begin
          state_ff <= is_read_ff ? H_WAIT_RD : H_NEXT;
        end
        H_WAIT_RD:
        begin
          if (bus.rvalid)
          begin
            if (!mode16_ff)
            begin
              rdata_ff <= bus.dq;
            end
            else if (half_ff)
            begin
              rdata_ff[31:16] <= bus.dq[15:0];
            end
            else
            begin
              rdata_ff[15:0] <= bus.dq[15:0];
            end
            state_ff <= H_NEXT;
          end
        end
        H_NEXT:
        begin
          if (mode16_ff && !half_ff)
          begin
            half_ff <= 1'b1;
            state_ff <= H_WAIT_RDY;
          end
          else
          begin
            state_ff <= H_IDLE;
          end
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end

  assign bus.addr = addr_ff;
  assign bus.wr = wr_ff;
  assign bus.rd = rd_ff;
  assign bus.wdata = out_ff;
endmodule // host_ctrl

// file: testbench/hbus_chk.sv
// Protocol checks on the parallel host bus between the two ends
`timescale 1ns/1ps
module hbus_chk (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [7:1] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic oe_lo,
  input wire logic oe_hi,
  input wire logic rvalid,
  input wire logic ready
);
  import hbus_pkg::*;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  // Paired halves leave the host three cycles apart while ready holds
  sequence wr_pair;
    wr ##3 wr;
  endsequence
  sequence same_dword;
    addr[7:2] == $past(addr[7:2], 3);
  endsequence
  // Register targets never enter the FIFO, so no push stall
  sequence fifo_pair;
    wr_pair ##0 (addr[7:2] != ORDER_OFF[7:2] && addr[7:2] != CFG_OFF[7:2]);
  endsequence
  rd_answer_a: assert property (rd |-> ##2 rvalid)
    else $error("read answer late");
  rvalid_cause_a: assert property (rvalid |-> $past(rd, 2))
    else $error("stray read answer");
  oe_window_a: assert property (oe_lo == rvalid)
    else $error("low lanes driven outside answer");
  upper_lane_a: assert property (oe_hi |-> oe_lo)
    else $error("upper lanes driven alone");
  one_read_a: assert property (rd |=> !rd [*2])
    else $error("second read outstanding");
  wr_ready_a: assert property (wr |-> $past(ready))
    else $error("write without ready");
  pair_addr_a: assert property (wr_pair |-> same_dword)
    else $error("pair left its dword");
  push_ready_a: assert property (fifo_pair |=> !ready)
    else $error("no stall after pair push");
  no_collide_a: assert property (!(wr && rd))
    else $error("read and write together");
endmodule // hbus_chk

// file: testbench/tb.sv
// Testbench: controller and device port joined over the host bus
`timescale 1ns/1ps
module tb;
  import hbus_pkg::*;
  logic i_mclk, i_nrst, strap, wr_ready, hwrite;
  logic hreadyout, hresp, wr_valid, rd_req, is_32;
  logic [1:0] htrans;
  logic [5:0] wr_addr, rd_addr;
  logic [31:0] haddr, hwdata, hrdata, wr_data, rd_data, q, e, rd_base;
  int errors, checks, cyc, reqs, n;
  hbus_if hif();
  host_ctrl u_host_ctrl (.i_mclk(i_mclk), .i_nrst(i_nrst), .bus(hif.host),
    .i_hsel(1'h1), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp));
  host_port_dev u_host_port_dev (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .bus(hif.dev), .i_width_strap(strap), .o_wr_valid(wr_valid),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .i_wr_ready(wr_ready),
    .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
    .o_is_32bit(is_32));
  hbus_chk u_hbus_chk (.i_mclk(i_mclk), .i_nrst(i_nrst), .addr(hif.addr),
    .wr(hif.wr), .rd(hif.rd), .oe_lo(hif.oe_lo), .oe_hi(hif.oe_hi),
    .rvalid(hif.rvalid), .ready(hif.ready));
  // User data depends on address so a wrong fetch shows
  assign rd_data = rd_base ^ {26'h0, rd_addr};
  function automatic logic [31:0] word(input logic [5:0] a);
    return rd_base ^ {26'h0, a};
  endfunction
  initial
  begin
    i_mclk = 1'h0;
    forever #10 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (rd_req === 1'h1)
      reqs <= reqs + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge i_mclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_mclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic go(input logic w, input logic m16, input logic [7:0] a,
                    input logic [31:0] d);
    ahb(1'h1, H_ADDR_OFF, {24'h0, a});
    ahb(1'h1, H_WDATA_OFF, d);
    ahb(1'h1, H_CTRL_OFF, {29'h0, m16, ~w, w});
  endtask
  task automatic fin;
    q = 32'h0;
    while (q[STAT_DONE_BIT] !== 1'h1)
      ahb(1'h0, H_STAT_OFF, 32'h0);
    ahb(1'h1, H_STAT_OFF, 32'h1 << STAT_DONE_BIT);
  endtask
  task automatic xfer(input logic w, input logic m16, input logic [7:0] a,
                      input logic [31:0] d);
    go(w, m16, a, d);
    fin();
    if (!w)
      ahb(1'h0, H_RDATA_OFF, 32'h0);
  endtask
  // Pops one entry; the consumer stalls between pops
  task automatic pop(input logic [5:0] a, input logic [31:0] d);
    while (wr_valid !== 1'h1)
      @(posedge i_mclk);
    check({26'h0, wr_addr}, {26'h0, a});
    check(wr_data, d);
    wr_ready <= 1'h1;
    @(posedge i_mclk);
    wr_ready <= 1'h0;
    @(posedge i_mclk);
  endtask
  initial
  begin
    i_nrst = 1'h0;
    strap = 1'h0;
    wr_ready = 1'h0;
    hwrite = 1'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    rd_base = 32'hA5C30F00;
    errors = 0;
    checks = 0;
    cyc = 0;
    reqs = 0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'h1;
    repeat (6) @(posedge i_mclk);
    check({31'h0, is_32}, 32'h0);
    xfer(1'h0, 1'h1, CFG_OFF, 32'h0);
    check({31'h0, q[CFG_WIDTH_BIT]}, 32'h0);
    xfer(1'h0, 1'h1, ORDER_OFF, 32'h0);
    check(q, ORDER_RST);
    xfer(1'h1, 1'h1, 8'h10, 32'h12345678);
    pop(6'h04, 32'h12345678);
    xfer(1'h1, 1'h1, ORDER_OFF, ORDER_SWAP);
    check({31'h0, wr_valid}, 32'h0);
    xfer(1'h1, 1'h1, 8'h14, 32'h12345678);
    pop(6'h05, 32'h56781234);
    e = word(6'h08);
    xfer(1'h0, 1'h1, 8'h20, 32'h0);
    check(q, {e[15:0], e[31:16]});
    xfer(1'h1, 1'h1, ORDER_OFF, ORDER_RST);
    xfer(1'h0, 1'h1, 8'h20, 32'h0);
    check(q, e);
    // Lone halves: a repeated half is dropped, either order pairs
    xfer(1'h1, 1'h0, 8'h10, 32'h1111);
    xfer(1'h1, 1'h0, 8'h10, 32'h2222);
    check({31'h0, wr_valid}, 32'h0);
    xfer(1'h1, 1'h0, 8'h12, 32'h3333);
    pop(6'h04, 32'h33331111);
    xfer(1'h1, 1'h0, 8'h22, 32'hAAAA);
    xfer(1'h1, 1'h0, 8'h20, 32'hBBBB);
    pop(6'h08, 32'hAAAABBBB);
    n = reqs;
    e = word(6'h04);
    xfer(1'h0, 1'h0, 8'h10, 32'h0);
    check(q, {16'h0, e[15:0]});
    xfer(1'h0, 1'h0, 8'h10, 32'h0);
    xfer(1'h0, 1'h0, 8'h12, 32'h0);
    check(q, {16'h0, e[31:16]});
    check(32'(reqs - n), 32'h2);
    strap <= 1'h1;
    repeat (6) @(posedge i_mclk);
    check({31'h0, is_32}, 32'h1);
    xfer(1'h0, 1'h0, CFG_OFF, 32'h0);
    check({31'h0, q[CFG_WIDTH_BIT]}, 32'h1);
    xfer(1'h1, 1'h0, ORDER_OFF, ORDER_SWAP);
    xfer(1'h1, 1'h0, 8'h30, 32'hCAFE0001);
    pop(6'h0C, 32'hCAFE0001);
    xfer(1'h0, 1'h0, 8'h30, 32'h0);
    check(q, word(6'h0C));
    for (int i = 0; i < 8; i++)
      xfer(1'h1, 1'h0, 8'(8'h40 + 4 * i), 32'(32'h100 + i));
    go(1'h1, 1'h0, 8'h60, 32'h108);
    repeat (4) @(posedge i_mclk);
    check({31'h0, hif.ready}, 32'h0);
    for (int i = 0; i < 9; i++)
      pop(6'(16 + i), 32'(32'h100 + i));
    fin();
    print_verdict();
  end
endmodule // tb
